/* hw/dram_ecc_pkg.sv */
// Shared constants for the symbol ECC datapath and its injection unit.
package dram_ecc_pkg;

  // Word geometry.
  localparam int DATA_W       = 128;
  localparam int CHECK_W      = 16;
  localparam int WORD_W       = 144;
  localparam int SYM_W        = 4;
  localparam int NUM_SYM      = 36;
  localparam int NUM_DATA_SYM = 32;
  localparam int SEG_W        = 16;
  localparam int NUM_SEG      = 9;
  localparam int SYN_W        = 16;
  localparam int SYM_IDX_W    = 6;
  localparam int ADDR_W       = 32;
  localparam int CORE_W       = 2;
  localparam int REG_ADDR_W   = 4;
  localparam int REG_DATA_W   = 32;

  // Cacheline is 64 bytes; each 16-byte quadrant is one ECC word.
  localparam int QUAD_LSB = 4;
  localparam int QUAD_W   = 2;

  // Register offsets.
  localparam logic [3:0] CTRL_OFS       = 4'h0;
  localparam logic [3:0] TARGET_OFS     = 4'h1;
  localparam logic [3:0] INJECT_OFS     = 4'h2;
  localparam logic [3:0] LOG_STATUS_OFS = 4'h3;
  localparam logic [3:0] LOG_ADDR_OFS   = 4'h4;
  localparam logic [3:0] ALIAS_STAT_OFS = 4'h5;
  localparam logic [3:0] ALIAS_ADDR_OFS = 4'h6;

  // Field positions.
  localparam int CTRL_MODULE_EN  = 0;
  localparam int CTRL_MEMORY_EN  = 1;
  localparam int CTRL_UNLOCK     = 2;
  localparam int CTRL_ROUTING    = 3;
  localparam int CTRL_SYM_WIDTH  = 4;
  localparam int TGT_ARRAY_LSB   = 0;
  localparam int TGT_QUAD_LSB    = 8;
  localparam int INJ_MASK_LSB    = 0;
  localparam int INJ_SEL_LSB     = 16;
  localparam int INJ_CONT        = 28;
  localparam int INJ_WR_REQ      = 29;
  localparam int INJ_RD_REQ      = 30;
  localparam int LOG_SYN_LSB     = 0;
  localparam int LOG_SYM_LSB     = 16;
  localparam int LOG_CE          = 24;
  localparam int LOG_UC          = 25;
  localparam int LOG_OVERFLOW    = 26;
  localparam int LOG_VALID       = 31;

  // Codes and reset values.
  localparam logic [3:0]  ARRAY_DRAM  = 4'h8;
  localparam logic        SYM_X4      = 1'b1;
  localparam logic [31:0] REG_RST     = 32'h0000_0000;
  localparam logic [5:0]  CHK_SYM0    = 6'h20;

  // Syndrome of a single set bit in each data symbol, bits 0..3.
  localparam logic [15:0] DATA_COL [0:127] = '{
    16'hE821, 16'h7C32, 16'hBB44, 16'hDD88,
    16'h5D31, 16'hA612, 16'h9584, 16'hEAC8,
    16'h0001, 16'h0002, 16'h0004, 16'h0008,
    16'h2021, 16'h3032, 16'h4044, 16'h8088,
    16'h5041, 16'hA082, 16'h9054, 16'hE0A8,
    16'hBE21, 16'hD732, 16'h2144, 16'h3288,
    16'h4951, 16'h8EA2, 16'h5394, 16'hA1E8,
    16'h74E1, 16'h9872, 16'hD6B4, 16'h6BD8,
    16'h15C1, 16'h2A42, 16'hCEF4, 16'h4758,
    16'h3D01, 16'h1602, 16'h8504, 16'hCA08,
    16'h9801, 16'hEC02, 16'h6B04, 16'hBD08,
    16'hD131, 16'h6212, 16'h3884, 16'h1CC8,
    16'hE1D1, 16'h7262, 16'hB834, 16'hDC18,
    16'h6051, 16'hB0A2, 16'h1094, 16'h20E8,
    16'hA4C1, 16'hF842, 16'hE6F4, 16'h7B58,
    16'h11C1, 16'h2242, 16'hC8F4, 16'h4C58,
    16'h45D1, 16'h8A62, 16'h5E34, 16'hA718,
    16'h63E1, 16'hB172, 16'h14B4, 16'h28D8,
    16'hB741, 16'hD982, 16'h2254, 16'h33A8,
    16'hDD41, 16'h6682, 16'h3554, 16'h1AA8,
    16'h2BD1, 16'h3D62, 16'h4F34, 16'h8518,
    16'h83C1, 16'hC142, 16'hA4F4, 16'hF858,
    16'h8FD1, 16'hC562, 16'hA934, 16'hFE18,
    16'h4791, 16'h89E2, 16'h5264, 16'hA3B8,
    16'h5781, 16'hA9C2, 16'h92A4, 16'hE3F8,
    16'hBF41, 16'hD582, 16'h2954, 16'h3EA8,
    16'h9391, 16'hE1E2, 16'h6464, 16'hB8B8,
    16'hCCE1, 16'h4472, 16'hFDB4, 16'h56D8,
    16'hA761, 16'hF9B2, 16'hE214, 16'h7328,
    16'hFF61, 16'h55B2, 16'h7914, 16'h9E28,
    16'h5451, 16'hA8A2, 16'h9694, 16'hEBE8,
    16'h6FC1, 16'hB542, 16'h19F4, 16'h2E58
  };

endpackage

/* hw/dram_symbol_ecc_and_injection.sv */
// Symbol ECC encode/decode, error log and error injection for a DRAM path.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module dram_symbol_ecc_and_injection
  import dram_ecc_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register port.
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [REG_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [CORE_W-1:0]     reg_core,
  output logic      [REG_DATA_W-1:0] reg_rdata,
  output logic                       status_write_fault,
  // Core that owns the shared bank.
  input  wire logic [CORE_W-1:0]     master_node_core,
  // Write path toward memory.
  input  wire logic                  wr_valid,
  input  wire logic                  wr_uncached,
  input  wire logic [ADDR_W-1:0]     wr_addr,
  input  wire logic [DATA_W-1:0]     wr_data,
  output logic                       wr_out_valid,
  output logic      [ADDR_W-1:0]     wr_out_addr,
  output logic      [WORD_W-1:0]     wr_out_word,
  output logic                       wr_out_injected,
  // Read path from memory.
  input  wire logic                  rd_valid,
  input  wire logic                  rd_uncached,
  input  wire logic [ADDR_W-1:0]     rd_addr,
  input  wire logic [WORD_W-1:0]     rd_word,
  input  wire logic [CORE_W-1:0]     rd_core,
  output logic                       rd_out_valid,
  output logic      [DATA_W-1:0]     rd_out_data,
  output logic                       rd_out_corrected,
  output logic                       rd_out_uncorrectable,
  // Machine check report.
  output logic                       mca_exception,
  output logic      [CORE_W-1:0]     mca_exception_core
);

  // Software state.
  logic [4:0]            ctrl_reg;
  logic [REG_DATA_W-1:0] target_reg;
  logic [REG_DATA_W-1:0] inject_reg;
  logic [REG_DATA_W-1:0] log_status_reg;
  logic [ADDR_W-1:0]     log_addr_reg;

  logic                  module_check_enable;
  logic                  memory_check_enable;
  logic                  mca_status_write_unlock;
  logic                  shared_bank_master_core_routing;
  logic [3:0]            target_array_choice;
  logic [QUAD_W-1:0]     target_quadrant_index;
  logic [SEG_W-1:0]      corrupt_bit_mask;
  logic [NUM_SEG-1:0]    corrupt_word_select;
  logic                  continuous_inject;
  logic                  single_write_inject_request;
  logic                  single_read_inject_request;

  assign module_check_enable             = ctrl_reg[CTRL_MODULE_EN];
  assign memory_check_enable             = ctrl_reg[CTRL_MEMORY_EN];
  assign mca_status_write_unlock         = ctrl_reg[CTRL_UNLOCK];
  assign shared_bank_master_core_routing = ctrl_reg[CTRL_ROUTING];
  assign target_array_choice   = target_reg[TGT_ARRAY_LSB +: 4];
  assign target_quadrant_index = target_reg[TGT_QUAD_LSB +: QUAD_W];
  assign corrupt_bit_mask      = inject_reg[INJ_MASK_LSB +: SEG_W];
  assign corrupt_word_select   = inject_reg[INJ_SEL_LSB +: NUM_SEG];
  assign continuous_inject           = inject_reg[INJ_CONT];
  assign single_write_inject_request = inject_reg[INJ_WR_REQ];
  assign single_read_inject_request  = inject_reg[INJ_RD_REQ];

  // Injection qualification.
  logic inject_ok;
  logic wr_fire;
  logic rd_fire;

  assign inject_ok = module_check_enable && memory_check_enable &&
                     (target_array_choice == ARRAY_DRAM);

  // Only the addressed access's own quadrant is hit, at its own address.
  assign wr_fire = wr_valid && wr_uncached && inject_ok &&
                   !single_read_inject_request &&
                   (continuous_inject || single_write_inject_request) &&
                   (wr_addr[QUAD_LSB +: QUAD_W] == target_quadrant_index);
  assign rd_fire = rd_valid && rd_uncached && inject_ok &&
                   single_read_inject_request &&
                   (rd_addr[QUAD_LSB +: QUAD_W] == target_quadrant_index);

  // Encoder: data symbol n is data bits 4n+3..4n.
  logic [SYN_W-1:0] enc_part [NUM_DATA_SYM];
  logic [SYN_W-1:0] dec_part [NUM_DATA_SYM];
  logic [SYN_W-1:0] dec_mix  [NUM_DATA_SYM];
  logic [WORD_W-1:0] rd_word_eff;
  logic [SYN_W-1:0]  syn;

  for (genvar n = 0; n < NUM_DATA_SYM; n++) begin : g_sym
    symbol_column_mix #(
      .COL0 (DATA_COL[4*n]),
      .COL1 (DATA_COL[4*n+1]),
      .COL2 (DATA_COL[4*n+2]),
      .COL3 (DATA_COL[4*n+3])
    ) u_enc (
      .nibble   (wr_data[n*SYM_W +: SYM_W]),
      .syndrome (enc_part[n])
    );
    symbol_column_mix #(
      .COL0 (DATA_COL[4*n]),
      .COL1 (DATA_COL[4*n+1]),
      .COL2 (DATA_COL[4*n+2]),
      .COL3 (DATA_COL[4*n+3])
    ) u_dec (
      .nibble   (rd_word_eff[n*SYM_W +: SYM_W]),
      .syndrome (dec_part[n])
    );
    symbol_column_mix #(
      .COL0 (DATA_COL[4*n]),
      .COL1 (DATA_COL[4*n+1]),
      .COL2 (DATA_COL[4*n+2]),
      .COL3 (DATA_COL[4*n+3])
    ) u_match (
      .nibble   (syn[SYM_W-1:0]),
      .syndrome (dec_mix[n])
    );
  end

  // Check symbols 20h..23h are solved so the stored word has zero syndrome.
  logic [SYN_W-1:0]   enc_par;
  logic [CHECK_W-1:0] enc_check;
  logic [WORD_W-1:0]  enc_word;
  logic [WORD_W-1:0]  inj_word;

  always_comb begin
    enc_par = '0;
    for (int n = 0; n < NUM_DATA_SYM; n++) begin
      enc_par = enc_par ^ enc_part[n];
    end
  end

  assign enc_check = {enc_par[3:0], enc_par[15:12], enc_par[11:8],
                      enc_par[7:4] ^ enc_par[3:0]};
  assign enc_word  = {enc_check, wr_data};

  word_corruptor u_wr_corrupt (
    .word_in    (enc_word),
    .seg_select (corrupt_word_select),
    .bit_mask   (corrupt_bit_mask),
    .fire       (wr_fire),
    .word_out   (inj_word)
  );

  word_corruptor u_rd_corrupt (
    .word_in    (rd_word),
    .seg_select (corrupt_word_select),
    .bit_mask   (corrupt_bit_mask),
    .fire       (rd_fire),
    .word_out   (rd_word_eff)
  );

  // Syndrome of the received word.
  logic [3:0] c20;
  logic [3:0] c21;
  logic [3:0] c22;
  logic [3:0] c23;

  assign c20 = rd_word_eff[DATA_W +: 4];
  assign c21 = rd_word_eff[DATA_W+4 +: 4];
  assign c22 = rd_word_eff[DATA_W+8 +: 4];
  assign c23 = rd_word_eff[DATA_W+12 +: 4];

  always_comb begin
    syn = {c22, c21, c20 ^ c23, c23};
    for (int n = 0; n < NUM_DATA_SYM; n++) begin
      syn = syn ^ dec_part[n];
    end
  end

  // Single-symbol locator and corrector.
  logic [DATA_W-1:0]    fix_data;
  logic                 sym_hit;
  logic [SYM_IDX_W-1:0] sym_idx;
  logic                 err_any;
  logic                 err_uc;

  always_comb begin
    fix_data = rd_word_eff[DATA_W-1:0];
    sym_hit  = 1'b0;
    sym_idx  = '0;
    for (int n = 0; n < NUM_DATA_SYM; n++) begin
      if (syn[3:0] != 4'h0 && dec_mix[n] == syn) begin
        fix_data[n*SYM_W +: SYM_W] = fix_data[n*SYM_W +: SYM_W] ^ syn[3:0];
        sym_hit = 1'b1;
        sym_idx = SYM_IDX_W'(n);
      end
    end
    if (syn[15:8] == 8'h00 && syn[3:0] == 4'h0 && syn[7:4] != 4'h0) begin
      sym_hit = 1'b1;
      sym_idx = CHK_SYM0;
    end
    if (syn[15:12] == 4'h0 && syn[7:0] == 8'h00 && syn[11:8] != 4'h0) begin
      sym_hit = 1'b1;
      sym_idx = CHK_SYM0 + 6'h01;
    end
    if (syn[11:0] == 12'h000 && syn[15:12] != 4'h0) begin
      sym_hit = 1'b1;
      sym_idx = CHK_SYM0 + 6'h02;
    end
    if (syn[15:8] == 8'h00 && syn[3:0] != 4'h0 && syn[7:4] == syn[3:0]) begin
      sym_hit = 1'b1;
      sym_idx = CHK_SYM0 + 6'h03;
    end
  end

  assign err_any = rd_valid && (syn != '0);
  assign err_uc  = err_any && !sym_hit;

  // Encoded write output.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_out_valid    <= 1'b0;
      wr_out_addr     <= '0;
      wr_out_word     <= '0;
      wr_out_injected <= 1'b0;
    end else begin
      wr_out_valid    <= wr_valid;
      wr_out_addr     <= wr_addr;
      wr_out_word     <= inj_word;
      wr_out_injected <= wr_fire;
    end
  end

  // Decoded read output; errors surface only when data is read back.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_out_valid         <= 1'b0;
      rd_out_data          <= '0;
      rd_out_corrected     <= 1'b0;
      rd_out_uncorrectable <= 1'b0;
    end else begin
      rd_out_valid         <= rd_valid;
      rd_out_data          <= fix_data;
      rd_out_corrected     <= err_any && sym_hit;
      rd_out_uncorrectable <= err_uc;
    end
  end

  // Exception goes to the master core when routing is on.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mca_exception      <= 1'b0;
      mca_exception_core <= '0;
    end else begin
      mca_exception      <= err_any;
      mca_exception_core <= shared_bank_master_core_routing ?
                            master_node_core : rd_core;
    end
  end

  // Register decode.
  logic bank_access_ok;
  logic wr_ctrl;
  logic wr_target;
  logic wr_inject;
  logic wr_log_stat;
  logic wr_log_addr;
  logic log_write_allowed;

  assign bank_access_ok = !shared_bank_master_core_routing ||
                          (reg_core == master_node_core);
  assign wr_ctrl     = reg_wr && reg_addr == CTRL_OFS;
  assign wr_target   = reg_wr && reg_addr == TARGET_OFS;
  assign wr_inject   = reg_wr && reg_addr == INJECT_OFS;
  assign wr_log_stat = reg_wr && reg_addr == LOG_STATUS_OFS && bank_access_ok;
  assign wr_log_addr = reg_wr && reg_addr == LOG_ADDR_OFS && bank_access_ok;
  assign log_write_allowed = mca_status_write_unlock || reg_wdata == '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= REG_RST[4:0];
      target_reg <= REG_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {SYM_X4, reg_wdata[3:0]};
      end
      if (wr_target) begin
        target_reg <= reg_wdata;
      end
    end
  end

  // Single-write request self-clears once applied; a new software write wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inject_reg <= REG_RST;
    end else if (wr_inject) begin
      inject_reg <= reg_wdata;
    end else begin
      if (wr_fire && single_write_inject_request) begin
        inject_reg[INJ_WR_REQ] <= 1'b0;
      end
      if (rd_fire) begin
        inject_reg[INJ_RD_REQ] <= 1'b0;
      end
    end
  end

  // Nonzero status writes need the unlock bit; otherwise they fault, except non-master writes under routing, which are dropped.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_write_fault <= 1'b0;
    end else begin
      status_write_fault <= (wr_log_stat || wr_log_addr) &&
                            !log_write_allowed;
    end
  end

  // Error log: a hardware error that is logged in the same cycle beats a software write; an error not logged only sets overflow.
  logic hw_take;

  assign hw_take = err_any && (!log_status_reg[LOG_VALID] ||
                   (err_uc && !log_status_reg[LOG_UC]));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      log_status_reg <= REG_RST;
    end else if (hw_take) begin
      log_status_reg                          <= '0;
      log_status_reg[LOG_SYN_LSB +: SYN_W]    <= syn;
      log_status_reg[LOG_SYM_LSB +: SYM_IDX_W] <= sym_hit ? sym_idx : '0;
      log_status_reg[LOG_CE]                  <= !err_uc;
      log_status_reg[LOG_UC]                  <= err_uc;
      log_status_reg[LOG_OVERFLOW]            <= log_status_reg[LOG_VALID];
      log_status_reg[LOG_VALID]               <= 1'b1;
    end else begin
      if (wr_log_stat && log_write_allowed) begin
        log_status_reg <= reg_wdata;
      end
      if (err_any) begin
        log_status_reg[LOG_OVERFLOW] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      log_addr_reg <= REG_RST;
    end else if (hw_take) begin
      log_addr_reg <= {rd_addr[ADDR_W-1:QUAD_LSB],
                       {QUAD_LSB{1'b0}}};
    end else if (wr_log_addr && log_write_allowed) begin
      log_addr_reg <= reg_wdata;
    end
  end

  // Read data stand for one cycle only.
  logic [REG_DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      CTRL_OFS:       rd_mux = {27'h0, ctrl_reg};
      TARGET_OFS:     rd_mux = target_reg;
      INJECT_OFS:     rd_mux = inject_reg;
      LOG_STATUS_OFS: rd_mux = bank_access_ok ? log_status_reg : '0;
      LOG_ADDR_OFS:   rd_mux = bank_access_ok ? log_addr_reg : '0;
      ALIAS_STAT_OFS: rd_mux = log_status_reg;
      ALIAS_ADDR_OFS: rd_mux = log_addr_reg;
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

endmodule

/* hw/symbol_column_mix.sv */
// Linear map of one 4-bit symbol pattern onto its 16-bit syndrome.
`timescale 1ns/1ps
module symbol_column_mix #(
  parameter logic [15:0] COL0 = 16'h0001,
  parameter logic [15:0] COL1 = 16'h0002,
  parameter logic [15:0] COL2 = 16'h0004,
  parameter logic [15:0] COL3 = 16'h0008
) (
  // Symbol pattern in, syndrome out.
  input  wire logic [3:0]  nibble,
  output logic      [15:0] syndrome
);

  assign syndrome = ({16{nibble[0]}} & COL0) ^ ({16{nibble[1]}} & COL1) ^
                    ({16{nibble[2]}} & COL2) ^ ({16{nibble[3]}} & COL3);

endmodule

/* hw/word_corruptor.sv */
// Flips the masked bits of every selected 16-bit word of an ECC word.
`timescale 1ns/1ps
module word_corruptor
  import dram_ecc_pkg::*;
(
  // Word and pattern.
  input  wire logic [WORD_W-1:0]  word_in,
  input  wire logic [NUM_SEG-1:0] seg_select,
  input  wire logic [SEG_W-1:0]   bit_mask,
  input  wire logic               fire,
  // Result.
  output logic      [WORD_W-1:0]  word_out
);

  always_comb begin
    word_out = word_in;
    for (int k = 0; k < NUM_SEG; k++) begin
      if (fire && seg_select[k]) begin
        word_out[k*SEG_W +: SEG_W] = word_in[k*SEG_W +: SEG_W] ^ bit_mask;
      end
    end
  end

endmodule

/* test/dimm_word_store.sv */
// Memory behind the controller: keeps written words and serves fetches.
`timescale 1ns/1ps
module dimm_word_store
  import dram_ecc_pkg::*;
(
  // Words from the controller.
  input  logic              clk,
  input  logic              wr_out_valid,
  input  logic [ADDR_W-1:0] wr_out_addr,
  input  logic [WORD_W-1:0] wr_out_word,
  // Fetch request and answer.
  input  logic              fetch,
  input  logic [ADDR_W-1:0] fetch_addr,
  input  logic              slow,
  output logic              rd_valid,
  output logic [ADDR_W-1:0] rd_addr,
  output logic [WORD_W-1:0] rd_word
);
  logic [WORD_W-1:0] mem [0:15];
  logic [ADDR_W-1:0] pend;
  int                wait_cnt = 0;

  initial rd_word = '0;

  // Between answers the data bus is released and shows a changing pattern.
  always @(posedge clk) begin
    rd_valid <= 1'b0;
    rd_word  <= ~rd_word;
    if (wr_out_valid) begin
      mem[wr_out_addr[7:4]] <= wr_out_word;
    end
    if (fetch) begin
      pend     <= fetch_addr;
      wait_cnt <= slow ? 4 : 1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
      rd_valid <= wait_cnt == 1;
      rd_addr  <= pend;
      rd_word  <= wait_cnt == 1 ? mem[pend[7:4]] : ~rd_word;
    end
  end
endmodule

/* test/dram_ecc_inject_assertions.sv */
// Port-level assertions for the symbol ECC and injection block.
`timescale 1ns/1ps
module dram_ecc_inject_assertions
  import dram_ecc_pkg::*;
(
  // Clock, reset and register port.
  input logic                  clk,
  input logic                  rst,
  input logic [REG_ADDR_W-1:0] reg_addr,
  input logic [REG_DATA_W-1:0] reg_wdata,
  input logic                  reg_wr,
  input logic                  status_write_fault,
  input logic [CORE_W-1:0]     master_node_core,
  // Write path.
  input logic                  wr_valid,
  input logic                  wr_uncached,
  input logic [ADDR_W-1:0]     wr_out_addr,
  input logic                  wr_out_injected,
  // Read path and report.
  input logic                  rd_valid,
  input logic [CORE_W-1:0]     rd_core,
  input logic                  rd_out_valid,
  input logic                  rd_out_corrected,
  input logic                  rd_out_uncorrectable,
  input logic                  mca_exception,
  input logic [CORE_W-1:0]     mca_exception_core
);
  logic [REG_DATA_W-1:0] ctrl_sh;
  logic [REG_DATA_W-1:0] tgt_sh;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // Software's view of the control and target registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_sh <= '0;
      tgt_sh  <= '0;
    end else if (reg_wr && reg_addr == CTRL_OFS) begin
      ctrl_sh <= reg_wdata;
    end else if (reg_wr && reg_addr == TARGET_OFS) begin
      tgt_sh <= reg_wdata;
    end
  end

  a_inject_enables: assert property (wr_out_injected |->
    $past(ctrl_sh[CTRL_MODULE_EN]) && $past(ctrl_sh[CTRL_MEMORY_EN]))
    else $error("injection with a check enable off");
  a_inject_target: assert property (wr_out_injected |->
    $past(tgt_sh[3:0]) == ARRAY_DRAM &&
    wr_out_addr[QUAD_LSB+:QUAD_W] == $past(tgt_sh[TGT_QUAD_LSB+:QUAD_W]))
    else $error("injection outside the target quadrant");
  a_cached_clean: assert property (wr_valid && !wr_uncached |=>
    !wr_out_injected) else $error("cached write corrupted");
  a_read_flags: assert property (rd_valid |=> rd_out_valid &&
    mca_exception == (rd_out_corrected || rd_out_uncorrectable))
    else $error("read flags and exception disagree");
  a_corr_excl: assert property (rd_out_corrected |->
    rd_out_valid && !rd_out_uncorrectable)
    else $error("word both corrected and uncorrectable");
  a_exc_core: assert property (mca_exception |->
    mca_exception_core == ($past(ctrl_sh[CTRL_ROUTING]) ?
    $past(master_node_core) : $past(rd_core)))
    else $error("exception at the wrong core");
  a_fault_cause: assert property (status_write_fault |->
    $past(reg_wr) && $past(reg_wdata) != '0 && !$past(ctrl_sh[CTRL_UNLOCK]))
    else $error("status fault without a locked nonzero write");
  a_fault_raise: assert property (reg_wr && reg_wdata != '0 &&
    reg_addr == LOG_STATUS_OFS && ctrl_sh[CTRL_ROUTING:CTRL_UNLOCK] == 2'h0
    |=> status_write_fault) else $error("locked status write not refused");
endmodule

bind dram_symbol_ecc_and_injection dram_ecc_inject_assertions u_chk (.*);

/* test/dram_symbol_ecc_and_injection_tb.sv */
// Directed bench for the symbol ECC and error injection block.
`timescale 1ns/1ps
module dram_symbol_ecc_and_injection_tb
  import dram_ecc_pkg::*;
;
  localparam logic [DATA_W-1:0] PAT =
    128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [REG_ADDR_W-1:0] reg_addr = '0;
  logic [REG_DATA_W-1:0] reg_wdata = '0;
  logic [REG_DATA_W-1:0] reg_rdata;
  logic [CORE_W-1:0]     reg_core = 2'h2;
  logic [CORE_W-1:0]     master_node_core = 2'h2;
  logic [CORE_W-1:0]     rd_core = 2'h1;
  logic [CORE_W-1:0]     mca_exception_core;
  logic                  wr_valid = 1'b0;
  logic                  wr_uncached = 1'b0;
  logic                  rd_uncached = 1'b1;
  logic                  fetch = 1'b0;
  logic                  slow = 1'b0;
  logic [ADDR_W-1:0]     wr_addr = '0;
  logic [ADDR_W-1:0]     fetch_addr = '0;
  logic [DATA_W-1:0]     wr_data = '0;
  logic [ADDR_W-1:0]     wr_out_addr, rd_addr;
  logic [WORD_W-1:0]     wr_out_word, rd_word;
  logic [DATA_W-1:0]     rd_out_data;
  logic                  wr_out_valid, wr_out_injected, status_write_fault;
  logic                  rd_valid, rd_out_valid, rd_out_corrected;
  logic                  rd_out_uncorrectable, mca_exception;
  int                    err_total = 0;
  int                    checks_done = 0;
  int                    cycles = 0;

  dram_symbol_ecc_and_injection u_dut (.*);
  dimm_word_store u_mem (.*);

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [WORD_W-1:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rchk(input string n, input logic [3:0] a,
                      input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(n, reg_rdata, e);
  endtask

  task automatic beat(input logic [31:0] a, input logic unc, inj,
                      input logic [DATA_W-1:0] flip);
    @(posedge clk);
    wr_valid    <= 1'b1;
    wr_addr     <= a;
    wr_uncached <= unc;
    wr_data     <= PAT;
    @(posedge clk);
    wr_valid    <= 1'b0;
    #1;
    chk("injected", wr_out_injected, inj);
    chk("stored data", wr_out_word[DATA_W-1:0], PAT ^ flip);
    chk("write valid", wr_out_valid, 1'b1);
    chk("write address", wr_out_addr, a);
  endtask

  // Fetch a stored word through the partner and judge the decoded result.
  task automatic mem(input logic [31:0] a, input logic ce, uc);
    @(posedge clk);
    fetch      <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch      <= 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (rd_out_valid === 1'b1) break;
    end
    chk("read valid", rd_out_valid, 1'b1);
    chk("corrected", rd_out_corrected, ce);
    chk("uncorrectable", rd_out_uncorrectable, uc);
    chk("exception", mca_exception, ce | uc);
    if (!uc) chk("read data", rd_out_data, PAT);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk("unmapped", 4'hF, 32'h0);
    wr(CTRL_OFS, 32'h3);
    rchk("ctrl", CTRL_OFS, 32'h13);
    wr(TARGET_OFS, 32'h108);
    wr(INJECT_OFS, 32'h2002_0030);
    beat(32'h10, 1'b0, 1'b0, '0);
    beat(32'h20, 1'b1, 1'b0, '0);
    beat(32'h10, 1'b1, 1'b1, 128'h30_0000);
    rchk("request cleared", INJECT_OFS, 32'h0002_0030);
    beat(32'h50, 1'b1, 1'b0, '0);
    mem(32'h10, 1'b1, 1'b0);
    rchk("log status", LOG_STATUS_OFS, 32'h8105_6913);
    rchk("log address", LOG_ADDR_OFS, 32'h10);
    slow <= 1'b1;
    mem(32'h50, 1'b0, 1'b0);
    slow <= 1'b0;
    $display("test single write done");
    wr(LOG_STATUS_OFS, 32'h0);
    wr(LOG_STATUS_OFS, 32'h1);
    chk("fault", status_write_fault, 1'b1);
    rchk("log kept", LOG_STATUS_OFS, 32'h0);
    wr(CTRL_OFS, 32'h7);
    wr(LOG_STATUS_OFS, 32'h1);
    chk("no fault", status_write_fault, 1'b0);
    rchk("log written", LOG_STATUS_OFS, 32'h1);
    wr(LOG_STATUS_OFS, 32'h0);
    $display("test status unlock done");
    wr(INJECT_OFS, 32'h1003_0001);
    beat(32'h10, 1'b1, 1'b1, 128'h1_0001);
    beat(32'h50, 1'b1, 1'b1, 128'h1_0001);
    rchk("continuous kept", INJECT_OFS, 32'h1003_0001);
    mem(32'h10, 1'b0, 1'b1);
    $display("test continuous done");
    wr(INJECT_OFS, 32'h2100_0001);
    beat(32'h90, 1'b1, 1'b1, '0);
    mem(32'h90, 1'b1, 1'b0);
    chk("exception core", mca_exception_core, 2'h1);
    wr(CTRL_OFS, 32'h1);
    wr(INJECT_OFS, 32'h2001_0001);
    beat(32'hD0, 1'b1, 1'b0, '0);
    $display("test check word and enables done");
    wr(CTRL_OFS, 32'hB);
    rchk("master log", LOG_ADDR_OFS, 32'h10);
    reg_core <= 2'h1;
    rchk("other core log", LOG_ADDR_OFS, 32'h0);
    rchk("alias", ALIAS_ADDR_OFS, 32'h10);
    mem(32'h90, 1'b1, 1'b0);
    chk("routed core", mca_exception_core, 2'h2);
    $display("test routing done");
    wr(INJECT_OFS, 32'h4001_0001);
    rd_uncached <= 1'b0;
    mem(32'hD0, 1'b0, 1'b0);
    rd_uncached <= 1'b1;
    mem(32'hD0, 1'b1, 1'b0);
    chk("read inject core", mca_exception_core, 2'h2);
    rchk("read request cleared", INJECT_OFS, 32'h0001_0001);
    $display("test read injection done");
    close_out();
  end
endmodule
